// ---- pkg/fsk_spreader_pkg.sv ----
`default_nettype none
package fsk_spreader_pkg;
  // ----------------------------------------
  // Widths and encodings
  // ----------------------------------------
  localparam int unsigned RATIO_W = 5;
  localparam int unsigned CNT_W = 4;
  localparam logic [4:0] RATIO_1 = 5'h01;
  localparam logic [4:0] RATIO_2 = 5'h02;
  localparam logic [4:0] RATIO_4 = 5'h04;
  localparam logic [4:0] RATIO_8 = 5'h08;
  localparam logic [4:0] RATIO_16 = 5'h10;
  localparam int unsigned FIFO_DEPTH = 4;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned SWITCH_MAX_US = 500;
  localparam int unsigned SWITCH_CYCLES = (SWITCH_MAX_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned SETTLE_CYCLES = 1000;
endpackage : fsk_spreader_pkg
`default_nettype wire

// ---- rtl/bit_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module bit_fifo #(
  parameter int unsigned WIDTH = 2,
  parameter int unsigned DEPTH = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_in_ready = (cnt_q < (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem_q[rd_q];

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : inc

  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= inc(wr_q);
      end
      if (pop) begin
        rd_q <= inc(rd_q);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : bit_fifo
`default_nettype wire

// ---- rtl/fsk_bit_spreader.sv ----
`timescale 1ns/1ps
`default_nettype none
module fsk_bit_spreader #(
  parameter int unsigned SWITCH_CYCLES = fsk_spreader_pkg::SWITCH_CYCLES,
  parameter int unsigned SETTLE_CYCLES = fsk_spreader_pkg::SETTLE_CYCLES,
  parameter int unsigned DEPTH = fsk_spreader_pkg::FIFO_DEPTH
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_spreading_enable_attr,
  input wire logic [4:0] i_spreading_ratio_attr,
  input wire logic i_whitening_enable_attr,
  input wire logic i_bit_valid,
  output logic o_bit_ready,
  input wire logic i_bit,
  input wire logic i_bit_payload,
  input wire logic i_bit_last,
  input wire logic i_chip_tick,
  output logic o_chip_valid,
  output logic o_chip,
  output logic o_chip_last,
  output logic o_dev_positive,
  output logic o_whiten_active,
  input wire logic i_chan_change,
  output logic o_chan_ready
);
  // ----------------------------------------
  // Input buffer: {last, payload, bit}
  // ----------------------------------------
  logic f_valid;
  logic f_ready;
  logic [2:0] f_data;
  logic in_ready;
  logic bit_push;

  // Only a completed handshake may enter the buffer
  assign bit_push = i_bit_valid && o_bit_ready;

  bit_fifo #(.WIDTH(3), .DEPTH(DEPTH)) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_in_valid(bit_push),
    .o_in_ready(in_ready),
    .i_in_data({i_bit_last, i_bit_payload, i_bit}),
    .o_out_valid(f_valid),
    .i_out_ready(f_ready),
    .o_out_data(f_data)
  );

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_bit_ready <= 1'b0;
    end else begin
      // Quiet cycle after a push, so the room seen is never stale
      o_bit_ready <= in_ready && !bit_push;
    end
  end

  // ----------------------------------------
  // Frame settings
  // ----------------------------------------
  function automatic logic [4:0] legal_ratio(input logic [4:0] r);
    unique case (r)
      fsk_spreader_pkg::RATIO_1, fsk_spreader_pkg::RATIO_2, fsk_spreader_pkg::RATIO_4,
      fsk_spreader_pkg::RATIO_8, fsk_spreader_pkg::RATIO_16: legal_ratio = r;
      default: legal_ratio = fsk_spreader_pkg::RATIO_1;
    endcase
  endfunction : legal_ratio

  logic in_frame_q;
  logic spread_en_q;
  logic [4:0] ratio_q;
  logic [3:0] chip_idx_q;
  logic busy_q;
  logic cur_bit_q;
  logic cur_last_q;
  logic cur_whit_q;
  logic [4:0] eff_ratio;
  logic take;
  logic chip_fire;
  logic bit_done;

  assign eff_ratio = spread_en_q ? ratio_q : fsk_spreader_pkg::RATIO_1;
  assign chip_fire = busy_q && i_chip_tick && o_chan_ready;
  assign bit_done = chip_fire && ({1'b0, chip_idx_q} == eff_ratio - 5'h01);
  assign take = f_valid && (!busy_q || bit_done);
  assign f_ready = take;

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      in_frame_q <= 1'b0;
      spread_en_q <= 1'b0;
      ratio_q <= fsk_spreader_pkg::RATIO_1;
    end else if (take && !in_frame_q) begin
      spread_en_q <= i_spreading_enable_attr;
      ratio_q <= legal_ratio(i_spreading_ratio_attr);
      in_frame_q <= !f_data[2];
    end else if (take && f_data[2]) begin
      in_frame_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Chip generator
  // ----------------------------------------
  // Whitening only tags payload chips; the scrambler sits downstream
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      busy_q <= 1'b0;
      cur_bit_q <= 1'b0;
      cur_last_q <= 1'b0;
      cur_whit_q <= 1'b0;
      chip_idx_q <= '0;
    end else if (take) begin
      busy_q <= 1'b1;
      cur_bit_q <= f_data[0];
      cur_last_q <= f_data[2];
      cur_whit_q <= f_data[1] && i_whitening_enable_attr;
      chip_idx_q <= '0;
    end else if (bit_done) begin
      busy_q <= 1'b0;
    end else if (chip_fire) begin
      chip_idx_q <= chip_idx_q + 4'h1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_chip_valid <= 1'b0;
      o_chip <= 1'b0;
      o_chip_last <= 1'b0;
      o_dev_positive <= 1'b0;
      o_whiten_active <= 1'b0;
    end else begin
      o_chip_valid <= chip_fire;
      if (chip_fire) begin
        // Flag moves with the chip, not with the next bit taken
        o_whiten_active <= cur_whit_q;
        o_chip <= cur_bit_q ^ chip_idx_q[0];
        o_dev_positive <= cur_bit_q ^ chip_idx_q[0];
        o_chip_last <= cur_last_q && bit_done;
      end
    end
  end

  // ----------------------------------------
  // Channel switch settling
  // ----------------------------------------
  // Settling shorter than the limit, so ready within the bound unless another change restarts it
  localparam int unsigned SET_W = $clog2(SETTLE_CYCLES + 1);
  logic [SET_W-1:0] settle_q;

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      settle_q <= '0;
      o_chan_ready <= 1'b1;
    end else if (i_chan_change) begin
      settle_q <= SET_W'(SETTLE_CYCLES);
      o_chan_ready <= 1'b0;
    end else if (settle_q > SET_W'(1)) begin
      settle_q <= settle_q - SET_W'(1);
    end else begin
      settle_q <= '0;
      o_chan_ready <= 1'b1;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [31:0] wait_q;
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst || o_chan_ready) begin
      wait_q <= '0;
    end else begin
      wait_q <= wait_q + 32'h0000_0001;
    end
  end

  a_chan_bound: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    wait_q <= SWITCH_CYCLES) else $error("Channel switch exceeds limit");
  a_chip_pattern: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    chip_fire |=> o_chip == ($past(cur_bit_q) ^ $past(chip_idx_q[0])))
    else $error("Chip pattern wrong");
  a_first_chip: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    take |=> chip_idx_q == 4'h0) else $error("First chip not c0");
  a_ratio_legal: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    ratio_q inside {5'h01, 5'h02, 5'h04, 5'h08, 5'h10}) else $error("Illegal ratio");
  a_no_spread: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (busy_q && !spread_en_q && chip_fire) |-> bit_done) else $error("Spread while off");
  a_dev_sign: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    o_chip_valid |-> o_dev_positive == o_chip) else $error("Deviation sign wrong");
  a_hold_cfg: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    in_frame_q |=> $stable(ratio_q) && $stable(spread_en_q)) else $error("Config moved");
  a_whiten_off: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (take && !i_whitening_enable_attr) |=> !cur_whit_q) else $error("Whitening while off");
  a_idx_range: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    busy_q |-> {1'b0, chip_idx_q} < eff_ratio) else $error("Chip index overran");

  c_spread16: cover property (@(posedge i_clk_sys) bit_done && ratio_q == 5'h10 && spread_en_q);
  c_plain: cover property (@(posedge i_clk_sys) bit_done && !spread_en_q);
  c_switch: cover property (@(posedge i_clk_sys) $rose(o_chan_ready));
  c_full: cover property (@(posedge i_clk_sys) !in_ready);
endmodule : fsk_bit_spreader
`default_nettype wire

// ---- bench/chip_tick_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Modulator side: chip-rate tick source
// ----------------------------------------
module chip_tick_model (
  input wire logic i_clk_sys,
  input wire logic i_slow,
  output logic o_chip_tick
);
  int gap_q = 0;
  initial o_chip_tick = 1'h0;
  // Slow mode leaves idle cycles so chips do not always run back to back
  always @(posedge i_clk_sys) begin
    if (gap_q == 0) begin
      o_chip_tick <= 1'h1;
      gap_q <= i_slow ? int'($urandom_range(3, 1)) : 0;
    end else begin
      o_chip_tick <= 1'h0;
      gap_q <= gap_q - 1;
    end
  end
endmodule : chip_tick_model
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_clk_sys = 1'h0;
  logic i_nrst = 1'h0;
  logic sp_en = 1'h0, wh_en = 1'h0, bv = 1'h0, bb = 1'h0, bp = 1'h0, bl = 1'h0;
  logic chg = 1'h0, slow = 1'h0;
  logic [4:0] ratio = 5'h01;
  logic tick, rdy, cv, chip, clast, dev, whit, crdy;
  logic [2:0] exp_q [$];
  logic [2:0] e;
  int mismatches = 0;
  int tests_run = 0;
  int k, n;
  // Legal ratios plus one illegal value that must fall back to one chip
  logic [4:0] ratios [6] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h03};
  initial forever #4 i_clk_sys = ~i_clk_sys;
  chip_tick_model partner (.i_clk_sys(i_clk_sys), .i_slow(slow), .o_chip_tick(tick));
  fsk_bit_spreader #(.SETTLE_CYCLES(4)) DUT (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_spreading_enable_attr(sp_en), .i_spreading_ratio_attr(ratio),
    .i_whitening_enable_attr(wh_en), .i_bit_valid(bv), .o_bit_ready(rdy), .i_bit(bb),
    .i_bit_payload(bp), .i_bit_last(bl), .i_chip_tick(tick), .o_chip_valid(cv),
    .o_chip(chip), .o_chip_last(clast), .o_dev_positive(dev), .o_whiten_active(whit),
    .i_chan_change(chg), .o_chan_ready(crdy));
  task automatic check(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  function automatic int chips_for(input logic en, input logic [4:0] r);
    if (!en) return 1;
    case (r)
      5'h02, 5'h04, 5'h08, 5'h10: return int'(r);
      default: return 1;
    endcase
  endfunction : chips_for
  // Monitor on the falling edge, where registered outputs are settled
  always @(negedge i_clk_sys) begin
    if (i_nrst && cv === 1'h1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 3'hx;
      check("chip", e[2], chip);
      check("chip_last", e[1], clast);
      check("whiten_active", e[0], whit);
      check("dev_positive", e[2], dev);
    end
  end
  task automatic send_bit(input logic b, input logic p, input logic l);
    int i;
    logic r;
    @(posedge i_clk_sys);
    #1;
    {bv, bb, bp, bl} = {1'h1, b, p, l};
    for (i = 0; i < 300; i++) begin
      r = rdy;
      @(posedge i_clk_sys);
      #1;
      if (r === 1'h1) break;
    end
    bv = 1'h0;
    if (i == 300) begin
      check("bit taken", 1'h1, 1'h0);
      complete_run();
    end
  endtask : send_bit
  task automatic send_frame(input int bits);
    int c, i, j;
    logic b, w;
    c = chips_for(sp_en, ratio);
    w = wh_en;
    for (i = 0; i < bits; i++) begin
      b = 1'($urandom);
      for (j = 0; j < c; j++) exp_q.push_back({b ^ j[0], (i == bits - 1) && (j == c - 1),
        w && (i > 0)});
      send_bit(b, i > 0, i == bits - 1);
      if (i == 2) {sp_en, ratio} = {~sp_en, 5'h08};
    end
  endtask : send_frame
  task automatic drain;
    for (n = 0; n < 3000 && exp_q.size() > 0; n++) @(posedge i_clk_sys);
    if (n == 3000) begin
      check("chips drained", 1'h1, 1'h0);
      complete_run();
    end
    @(posedge i_clk_sys);
    #1;
  endtask : drain
  initial begin
    void'($urandom(89));
    repeat (8) @(posedge i_clk_sys);
    #1 i_nrst = 1'h1;
    check("chan_ready after reset", 1'h1, crdy);
    for (k = 0; k < 12; k++) begin
      {sp_en, ratio, wh_en, slow} = {k < 6 || k[0], ratios[k % 6], k[1], k[2]};
      send_frame(4 + int'($urandom_range(3)));
      drain();
    end
    chg = 1'h1;
    @(posedge i_clk_sys);
    #1 chg = 1'h0;
    check("chan_ready settling", 1'h0, crdy);
    for (n = 0; n < 100 && crdy !== 1'h1; n++) begin
      @(posedge i_clk_sys);
      #1;
    end
    check("settle bounded", 1'h1, n <= 4);
    complete_run();
  end
endmodule : tb
`default_nettype wire
